// File: hw/sdram_burst_pkg.sv
// Shared constants for the SDRAM command, mode and burst logic.
package sdram_burst_pkg;

  localparam int MODE_W   = 12;
  localparam int COL_W    = 10;
  localparam int ROW_W    = 13;
  localparam int BANK_W   = 2;
  localparam int BANKS    = 4;
  localparam int BEAT_W   = 11;

  // Mode word field positions.
  localparam int BL_LSB   = 0;
  localparam int BL_W     = 3;
  localparam int BT_BIT   = 3;
  localparam int CL_LSB   = 4;
  localparam int CL_W     = 3;
  localparam int OPM_LSB  = 7;
  localparam int WBM_BIT  = 9;

  // Address bit that carries auto-precharge or precharge-all.
  localparam int AP_BIT   = 10;

  // Burst length codes.
  localparam logic [2:0] BL_ONE   = 3'h0;
  localparam logic [2:0] BL_TWO   = 3'h1;
  localparam logic [2:0] BL_FOUR  = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_FULL  = 3'h7;

  // Block masks over the column bits for each burst length.
  localparam logic [9:0] MASK_ONE   = 10'h000;
  localparam logic [9:0] MASK_TWO   = 10'h001;
  localparam logic [9:0] MASK_FOUR  = 10'h003;
  localparam logic [9:0] MASK_EIGHT = 10'h007;
  localparam logic [9:0] MASK_FULL  = 10'h3FF;

  // Read latency codes.
  localparam logic [2:0] CL_TWO   = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;

  // Mode word after reset: one-beat sequential bursts, latency two.
  localparam logic [11:0] MODE_RESET = 12'h020;

  // Read mask acts two clocks after it is sampled.
  localparam int READ_MASK_DELAY = 2;

  // Engine states, Gray coded along idle, read, write.
  typedef enum logic [1:0] {
    ST_IDLE     = 2'h0,
    ST_BURST_RD = 2'h1,
    ST_BURST_WR = 2'h3,
    ST_SELF_REF = 2'h2
  } eng_state_e;

endpackage

// File: hw/burst_col_order.sv
// Column address of one burst beat, for every length and burst type.
`timescale 1ns/10ps
module burst_col_order (
  input  wire logic [9:0] start_col,
  input  wire logic [9:0] beat,
  input  wire logic [9:0] block_mask,
  input  wire logic       interleave,
  output logic      [9:0] col
);
  logic [9:0] offset;

  always_comb begin
    // Interleaved order XORs, sequential order adds within the block.
    if (interleave) begin
      offset = start_col ^ beat;
    end else begin
      offset = start_col + beat;
    end
    // Upper bits stay those of the start, so the burst wraps in place.
    col = (start_col & ~block_mask) | (offset & block_mask);
  end
endmodule

// File: hw/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic             spare_valid;
  logic [WIDTH-1:0] spare_data;

  // The spare slot catches a word that arrives while the head is stalled.
  assign in_ready = !spare_valid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid   <= 1'b0;
      out_data    <= '0;
      spare_valid <= 1'b0;
      spare_data  <= '0;
    end else if (!out_valid || out_ready) begin
      if (spare_valid) begin
        out_data    <= spare_data;
        spare_valid <= 1'b0;
      end else if (in_valid) begin
        out_valid <= 1'b1;
        out_data  <= in_data;
      end else begin
        out_valid <= 1'b0;
      end
    end else if (in_valid && in_ready) begin
      spare_valid <= 1'b1;
      spare_data  <= in_data;
    end
  end
endmodule

// File: hw/sdram_cmd_burst.sv
// Command decode, mode word and burst sequencing of the SDRAM device.
//
// Notes on behaviour
// - Mode bit picks sequential or interleaved order.
// - Two-beat burst toggles column bit zero.
// - Four-beat burst adds or XORs low bits.
// - Eight-beat burst adds or XORs low bits.
// - Bursts wrap inside their column block.
// - Full page steps sequentially through row.
// - One-beat burst ignores the burst type.
// - Read latency is two or three cycles.
// - Drive from edge n+m-1, valid n+m.
// - Write burst mode bit forces single writes.
// - Decode inhibit, no-op, activate, read, write.
// - Decode terminate, precharge, refresh, mode load.
// - Activate takes row and bank.
// - Read/write take column; bit ten auto-precharges.
// - Precharge one bank, or all with bit ten.
// - Refresh is auto or self by clock enable.
// - Refresh row comes from internal counter.
// - Mode load stores twelve low address bits.
// - Byte masks gate writes now, reads later.
// - Mode fields: length, type, latency, reserved.
// - Lengths one to eight, full page sequential.
`timescale 1ns/10ps
module sdram_cmd_burst #(
  parameter int DQ_W  = 64,
  parameter int LANES = 8
) (
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  input  wire logic                               cke,
  input  wire logic                               cs_n,
  input  wire logic                               ras_n,
  input  wire logic                               cas_n,
  input  wire logic                               we_n,
  input  wire logic [sdram_burst_pkg::BANK_W-1:0] ba,
  input  wire logic [sdram_burst_pkg::ROW_W-1:0]  addr,
  input  wire logic [LANES-1:0]                   byte_lane_mask,
  input  wire logic [DQ_W-1:0]                    dq_in,
  output logic      [DQ_W-1:0]                    dq_out,
  output logic      [LANES-1:0]                   dq_oe,
  output logic                                    rd_en,
  output logic      [sdram_burst_pkg::BANK_W-1:0] rd_bank,
  output logic      [sdram_burst_pkg::ROW_W-1:0]  rd_row,
  output logic      [sdram_burst_pkg::COL_W-1:0]  rd_col,
  input  wire logic [DQ_W-1:0]                    rd_data,
  output logic                                    wr_valid,
  input  wire logic                               wr_ready,
  output logic      [sdram_burst_pkg::BANK_W-1:0] wr_bank,
  output logic      [sdram_burst_pkg::ROW_W-1:0]  wr_row,
  output logic      [sdram_burst_pkg::COL_W-1:0]  wr_col,
  output logic      [DQ_W-1:0]                    wr_data,
  output logic      [LANES-1:0]                   wr_mask,
  output logic                                    refresh_pulse,
  output logic      [sdram_burst_pkg::ROW_W-1:0]  refresh_row,
  output logic                                    self_refresh,
  output logic      [sdram_burst_pkg::BANKS-1:0]  bank_open,
  output logic      [sdram_burst_pkg::MODE_W-1:0] mode_word,
  output logic                                    write_dropped
);
  localparam int WB_W = sdram_burst_pkg::BANK_W + sdram_burst_pkg::ROW_W
                      + sdram_burst_pkg::COL_W + DQ_W + LANES;

  sdram_burst_pkg::eng_state_e state;

  logic [sdram_burst_pkg::ROW_W-1:0]  open_row [sdram_burst_pkg::BANKS];
  logic [sdram_burst_pkg::ROW_W-1:0]  refresh_cnt;
  logic [LANES-1:0]                   mask_d1;
  logic [sdram_burst_pkg::BANK_W-1:0] eng_bank;
  logic [9:0]                         eng_base;
  logic [9:0]                         eng_mask;
  logic [10:0]                        eng_beat;
  logic [10:0]                        eng_len;
  logic                               eng_ilv;
  logic                               eng_ap;
  logic [9:0]                         cur_col;

  logic       cmd_ok;
  logic       is_act;
  logic       is_read;
  logic       is_write;
  logic       is_term;
  logic       is_pre;
  logic       is_ref;
  logic       is_lmr;
  logic       is_self;
  logic [2:0] bl_code;
  logic       cl3;
  logic       wbm;
  logic       full_page;
  logic [9:0] len_mask;
  logic       ilv_cmd;
  logic       issue_now;
  logic       last_beat;
  logic       direct_rd;
  logic       ap_close;
  logic       wb_in_valid;
  logic       wb_in_ready;
  logic [sdram_burst_pkg::BANK_W-1:0] ap_bank;
  logic [sdram_burst_pkg::BANK_W-1:0] wb_bank;
  logic [9:0]                         wb_col;
  logic [WB_W-1:0]                    wb_out;

  // Commands count only with clock enable high and outside self refresh.
  assign cmd_ok   = cke && !cs_n && (state != sdram_burst_pkg::ST_SELF_REF);
  assign is_act   = cmd_ok && ({ras_n, cas_n, we_n} == 3'h3);
  assign is_read  = cmd_ok && ({ras_n, cas_n, we_n} == 3'h5);
  assign is_write = cmd_ok && ({ras_n, cas_n, we_n} == 3'h4);
  assign is_term  = cmd_ok && ({ras_n, cas_n, we_n} == 3'h6);
  assign is_pre   = cmd_ok && ({ras_n, cas_n, we_n} == 3'h2);
  assign is_ref   = cmd_ok && ({ras_n, cas_n, we_n} == 3'h1);
  assign is_lmr   = cmd_ok && ({ras_n, cas_n, we_n} == 3'h0);
  assign is_self  = !cke && !cs_n && ({ras_n, cas_n, we_n} == 3'h1)
                  && (state != sdram_burst_pkg::ST_SELF_REF);

  assign bl_code   = mode_word[sdram_burst_pkg::BL_LSB
                               +: sdram_burst_pkg::BL_W];
  assign cl3       = mode_word[sdram_burst_pkg::CL_LSB +: sdram_burst_pkg::CL_W]
                     == sdram_burst_pkg::CL_THREE;
  assign wbm       = mode_word[sdram_burst_pkg::WBM_BIT];
  assign full_page = (bl_code == sdram_burst_pkg::BL_FULL);
  // Interleave has no meaning for full page or single beats.
  assign ilv_cmd   = mode_word[sdram_burst_pkg::BT_BIT]
                     && !full_page;

  always_comb begin
    // Reserved length codes fall back to single beats.
    case (bl_code)
      sdram_burst_pkg::BL_TWO:   len_mask = sdram_burst_pkg::MASK_TWO;
      sdram_burst_pkg::BL_FOUR:  len_mask = sdram_burst_pkg::MASK_FOUR;
      sdram_burst_pkg::BL_EIGHT: len_mask = sdram_burst_pkg::MASK_EIGHT;
      sdram_burst_pkg::BL_FULL:  len_mask = sdram_burst_pkg::MASK_FULL;
      default:                   len_mask = sdram_burst_pkg::MASK_ONE;
    endcase
  end

  burst_col_order u_col_order (
    .start_col  (eng_base),
    .beat       (eng_beat[9:0]),
    .block_mask (eng_mask),
    .interleave (eng_ilv),
    .col        (cur_col)
  );

  // A new burst or a terminate takes over from the running burst.
  assign issue_now = ((state == sdram_burst_pkg::ST_BURST_RD)
                   || (state == sdram_burst_pkg::ST_BURST_WR))
                   && !is_read && !is_write && !is_term;
  assign last_beat = (eng_beat == eng_len - 11'h001);
  assign direct_rd = is_read && !cl3;

  // Single writes and latency-two single reads close their bank at once; bursts and latency-three reads on their last beat.
  always_comb begin
    ap_close = 1'b0;
    ap_bank  = eng_bank;
    if ((direct_rd || is_write) && addr[sdram_burst_pkg::AP_BIT]
        && ((is_write && wbm) || (len_mask == sdram_burst_pkg::MASK_ONE))) begin
      ap_close = 1'b1;
      ap_bank  = ba;
    end else if (issue_now && last_beat && eng_ap) begin
      ap_close = 1'b1;
    end
  end

  // Burst engine: one column per clock after the first one.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= sdram_burst_pkg::ST_IDLE;
      self_refresh <= 1'b0;
      eng_bank     <= '0;
      eng_base     <= '0;
      eng_mask     <= '0;
      eng_beat     <= '0;
      eng_len      <= '0;
      eng_ilv      <= 1'b0;
      eng_ap       <= 1'b0;
    end else if (is_read || is_write) begin
      eng_bank <= ba;
      eng_base <= addr[9:0];
      eng_ap   <= addr[sdram_burst_pkg::AP_BIT];
      if (is_write && wbm) begin
        eng_mask <= sdram_burst_pkg::MASK_ONE;
        eng_len  <= 11'h001;
        eng_ilv  <= 1'b0;
      end else begin
        eng_mask <= len_mask;
        eng_len  <= {1'b0, len_mask} + 11'h001;
        eng_ilv  <= ilv_cmd;
      end
      if (is_read && cl3) begin
        // Latency three starts issuing one clock later.
        eng_beat <= 11'h000;
        state    <= sdram_burst_pkg::ST_BURST_RD;
      end else begin
        eng_beat <= 11'h001;
        if ((is_write && wbm) || (len_mask == sdram_burst_pkg::MASK_ONE)) begin
          state <= sdram_burst_pkg::ST_IDLE;
        end else if (is_read) begin
          state <= sdram_burst_pkg::ST_BURST_RD;
        end else begin
          state <= sdram_burst_pkg::ST_BURST_WR;
        end
      end
    end else if (is_term) begin
      state <= sdram_burst_pkg::ST_IDLE;
    end else if (is_self) begin
      state        <= sdram_burst_pkg::ST_SELF_REF;
      self_refresh <= 1'b1;
    end else if (state == sdram_burst_pkg::ST_SELF_REF) begin
      if (cke) begin
        state        <= sdram_burst_pkg::ST_IDLE;
        self_refresh <= 1'b0;
      end
    end else if (issue_now) begin
      if (last_beat) begin
        state <= sdram_burst_pkg::ST_IDLE;
      end else begin
        eng_beat <= eng_beat + 11'h001;
      end
    end
  end

  // Mode word load; reserved and operating bits are stored as given.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_word <= sdram_burst_pkg::MODE_RESET;
    end else if (is_lmr) begin
      mode_word <= addr[sdram_burst_pkg::MODE_W-1:0];
    end
  end

  // Per-bank open row tracking.
  for (genvar b = 0; b < sdram_burst_pkg::BANKS; b++) begin : g_bank
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        bank_open[b] <= 1'b0;
        open_row[b]  <= '0;
      end else if (is_act && (ba == 2'(b))) begin
        bank_open[b] <= 1'b1;
        open_row[b]  <= addr;
      end else if (is_pre && (addr[sdram_burst_pkg::AP_BIT]
                   || (ba == 2'(b)))) begin
        bank_open[b] <= 1'b0;
      end else if (ap_close && (ap_bank == b[1:0])) begin
        bank_open[b] <= 1'b0;
      end
    end
  end

  // Refresh rows come from the internal counter, never from the pins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_pulse <= 1'b0;
      refresh_row   <= '0;
      refresh_cnt   <= '0;
    end else begin
      refresh_pulse <= is_ref;
      if (is_ref) begin
        refresh_row <= refresh_cnt;
        refresh_cnt <= refresh_cnt + 13'h0001;
      end
    end
  end

  // Read port: the array answers in the same clock as the request.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_en   <= 1'b0;
      rd_bank <= '0;
      rd_row  <= '0;
      rd_col  <= '0;
    end else begin
      rd_en <= direct_rd || (issue_now
               && (state == sdram_burst_pkg::ST_BURST_RD));
      if (direct_rd) begin
        rd_bank <= ba;
        rd_row  <= open_row[ba];
        rd_col  <= addr[9:0];
      end else begin
        rd_bank <= eng_bank;
        rd_row  <= open_row[eng_bank];
        rd_col  <= cur_col;
      end
    end
  end

  // The read mask is sampled one clock before it gates the driver.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_d1 <= '0;
      dq_out  <= '0;
      dq_oe   <= '0;
    end else begin
      mask_d1 <= byte_lane_mask;
      if (rd_en) begin
        dq_out <= rd_data;
        dq_oe  <= ~mask_d1;
      end else begin
        dq_oe <= '0;
      end
    end
  end

  // Write beats: data and mask are taken on the beat's own edge.
  assign wb_in_valid = is_write || (issue_now
                       && (state == sdram_burst_pkg::ST_BURST_WR));
  assign wb_bank = is_write ? ba : eng_bank;
  assign wb_col  = is_write ? addr[9:0] : cur_col;

  // The array may stall; two words ride out a short stall unharmed.
  two_entry_buffer #(
    .WIDTH (WB_W)
  ) u_wbuf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (wb_in_valid),
    .in_ready  (wb_in_ready),
    .in_data   ({wb_bank, open_row[wb_bank], wb_col, dq_in,
                 byte_lane_mask}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wb_out)
  );
  assign {wr_bank, wr_row, wr_col, wr_data, wr_mask} = wb_out;

  // The pins cannot be stalled, so a longer stall can only be reported.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_dropped <= 1'b0;
    end else if (wb_in_valid && !wb_in_ready) begin
      write_dropped <= 1'b1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_cl2_first_beat: assert property (
    is_read && !cl3 |=> rd_en && rd_col == $past(addr[9:0])
                        ##1 dq_oe == ~$past(mask_d1))
    else $error("latency two read not issued on time");
  a_cl3_first_beat: assert property (
    is_read && cl3 |=> !rd_en
    ##1 ((rd_en && rd_col == $past(eng_base))
         || $past(is_read || is_write || is_term)))
    else $error("latency three read not issued on time");
  a_no_drive: assert property (
    !rd_en |=> dq_oe == '0)
    else $error("data driven without a read beat");
  a_block_wrap: assert property (
    issue_now |-> ((cur_col ^ eng_base) & ~eng_mask) == 10'h000)
    else $error("burst left its column block");
  a_page_step: assert property (
    rd_en && $past(rd_en) && full_page && !$past(is_read)
    && !$past(is_read, 2) |-> rd_col == $past(rd_col) + 10'h001)
    else $error("full page burst did not step by one");
  a_mode_load: assert property (
    is_lmr |=> mode_word == $past(addr[11:0]))
    else $error("mode word not loaded");
  a_precharge_all: assert property (
    is_pre && addr[sdram_burst_pkg::AP_BIT] && !is_act |=> bank_open == '0)
    else $error("precharge all left a bank open");
  a_activate: assert property (
    is_act |=> bank_open[$past(ba)])
    else $error("activate did not open the bank");
  a_single_write: assert property (
    is_write && wbm |=> state == sdram_burst_pkg::ST_IDLE)
    else $error("write burst ran with single write mode");
  a_refresh_count: assert property (
    is_ref |=> refresh_pulse && refresh_cnt == $past(refresh_cnt) + 13'h0001)
    else $error("refresh counter did not advance");
endmodule

// File: sim/sdram_array_model.sv
// Array-side model that answers reads at once and takes writes with stalls.
`timescale 1ns/10ps
module sdram_array_model (
  input  wire logic        core_clk,
  input  wire logic        rd_en,
  input  wire logic [1:0]  rd_bank,
  input  wire logic [12:0] rd_row,
  input  wire logic [9:0]  rd_col,
  output logic      [63:0] rd_data,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [9:0]  wr_col,
  input  wire logic [63:0] wr_data,
  input  wire logic [7:0]  wr_mask,
  input  wire logic        stall
);
  logic [63:0] pat;
  logic [81:0] wq[$];
  assign pat = {39'h0, rd_bank, rd_row, rd_col};
  // Off-beat data is inverted so that a late sample cannot match.
  assign rd_data = rd_en ? pat : ~pat;
  assign wr_ready = ~stall;
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) begin
      wq.push_back({wr_col, wr_mask, wr_data});
    end
  end
endmodule

// File: sim/sdram_cmd_burst_test.sv
// Self-checking bench for the SDRAM command, mode and burst logic.
`timescale 1ns/10ps
module sdram_cmd_burst_test;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] BST = 4'h6, PRE = 4'h2, REF = 4'h1, MRS = 4'h0;
  localparam logic [12:0] ROW = 13'h1ABC;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cke = 1'b1;
  logic        stall = 1'b0;
  logic [3:0]  cb = 4'hF;
  logic [1:0]  ba = 2'h0;
  logic [12:0] addr = 13'h0;
  logic [7:0]  msk = 8'h0;
  logic [63:0] dq_in = 64'h0;
  logic [63:0] dq_out, rd_data, wr_data, first;
  logic [7:0]  dq_oe, wr_mask, oe;
  logic        rd_en, wr_valid, wr_ready, refresh_pulse;
  logic        self_refresh, write_dropped, il;
  logic [1:0]  rd_bank, wr_bank;
  logic [12:0] rd_row, wr_row, refresh_row, r0;
  logic [9:0]  rd_col, wr_col, s, m;
  logic [3:0]  bank_open;
  logic [11:0] mode_word;
  logic [2:0]  bl, cl;
  logic [9:0]  got[$];
  int          fails = 0, cmp_count = 0, cyc = 0, lat, n;

  always #2 core_clk = ~core_clk;

  sdram_cmd_burst DUT (
    .core_clk(core_clk), .rst_n(rst_n), .cke(cke), .cs_n(cb[3]),
    .ras_n(cb[2]), .cas_n(cb[1]), .we_n(cb[0]), .ba(ba), .addr(addr),
    .byte_lane_mask(msk), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .rd_en(rd_en), .rd_bank(rd_bank), .rd_row(rd_row), .rd_col(rd_col),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_bank(wr_bank), .wr_row(wr_row), .wr_col(wr_col),
    .wr_data(wr_data), .wr_mask(wr_mask), .refresh_pulse(refresh_pulse),
    .refresh_row(refresh_row), .self_refresh(self_refresh),
    .bank_open(bank_open), .mode_word(mode_word),
    .write_dropped(write_dropped));

  sdram_array_model P (
    .core_clk(core_clk), .rd_en(rd_en), .rd_bank(rd_bank),
    .rd_row(rd_row), .rd_col(rd_col), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_col(wr_col),
    .wr_data(wr_data), .wr_mask(wr_mask), .stall(stall));

  // Every issued read beat is logged; each read test clears the log first.
  always @(negedge core_clk) begin
    if (rd_en === 1'b1) begin
      got.push_back(rd_col);
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      $display("CHECK FAILED %0t timeout", $time);
      test_done();
    end
  end

  task automatic chk(input logic [95:0] g, input logic [95:0] e,
                     input string msg);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // Returns just after the edge that takes the command.
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [12:0] a, input logic k);
    @(posedge core_clk);
    cb <= c;
    ba <= b;
    addr <= a;
    cke <= k;
    @(posedge core_clk);
    cb <= NOP;
    #1;
  endtask

  function automatic logic [9:0] ecol(input logic [9:0] st, input int k,
                                      input logic [9:0] mk, input logic x);
    logic [9:0] kk;
    kk = 10'(k);
    return (st & ~mk) | ((x ? (st ^ kk) : (st + kk)) & mk);
  endfunction

  // Banks are closed before the load and bank two is opened after it, so the load never meets an open row.
  task automatic load_mode(input logic [2:0] b, input logic t,
                           input logic [2:0] c, input logic w);
    cmd(PRE, 2'h0, 13'h0400, 1'b1);
    cmd(MRS, 2'h0, {3'h0, w, 2'h0, c, t, b}, 1'b1);
    chk(mode_word, {2'h0, w, 2'h0, c, t, b}, "mode word");
    cmd(ACT, 2'h2, ROW, 1'b1);
  endtask

  task automatic rd(input logic [9:0] sc, input logic ap);
    got.delete();
    lat = -1;
    cmd(RD, 2'h2, {2'h0, ap, sc}, 1'b1);
    for (int i = 0; i < 14; i++) begin
      @(negedge core_clk);
      if (lat < 0 && dq_oe !== 8'h0) begin
        lat = i;
        first = dq_out;
        oe = dq_oe;
      end
    end
  endtask

  task automatic wr(input logic [9:0] sc);
    P.wq.delete();
    @(posedge core_clk);
    cb <= WR;
    ba <= 2'h2;
    addr <= {3'h0, sc};
    dq_in <= 64'h100;
    msk <= 8'h0;
    for (int k = 1; k < 8; k++) begin
      @(posedge core_clk);
      cb <= NOP;
      dq_in <= 64'h100 + 64'(k);
      msk <= 8'(k);
    end
    @(posedge core_clk);
    msk <= 8'h0;
    repeat (12) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(mode_word, 12'h020, "reset mode");
    chk(bank_open, 4'h0, "reset banks");
    $display("test reset done");
    for (int t = 0; t < 16; t++) begin
      bl = 3'(t / 4);
      il = t[1];
      s = t[0] ? 10'h3F5 : 10'h0FA;
      cl = t[0] ? 3'h3 : 3'h2;
      n = 1 << bl;
      m = 10'(n - 1);
      load_mode(bl, il, cl, 1'b0);
      rd(s, 1'b0);
      chk(64'(got.size()), 64'(n), "beat count");
      for (int k = 0; k < n; k++) begin
        chk(got[k], ecol(s, k, m, il), "column");
      end
      chk(64'(lat), 64'(cl - 1), "latency");
      chk(first, {39'h0, 2'h2, ROW, ecol(s, 0, m, il)}, "data");
    end
    load_mode(3'h7, 1'b1, 3'h2, 1'b0);
    got.delete();
    cmd(RD, 2'h2, 13'h03FE, 1'b1);
    repeat (3) @(posedge core_clk);
    cmd(BST, 2'h0, 13'h0, 1'b1);
    repeat (6) @(negedge core_clk);
    chk(64'(got.size()), 64'h5, "terminate");
    for (int k = 0; k < 5; k++) begin
      chk(got[k], ecol(10'h3FE, k, 10'h3FF, 1'b0), "page");
    end
    msk <= 8'hA5;
    load_mode(3'h0, 1'b0, 3'h2, 1'b0);
    rd(10'h011, 1'b1);
    chk(oe, 8'h5A, "read mask");
    chk(bank_open, 4'h0, "auto close");
    $display("test reads done");
    load_mode(3'h2, 1'b0, 3'h2, 1'b0);
    wr(10'h006);
    chk(64'(P.wq.size()), 64'h4, "write beats");
    for (int k = 0; k < 4; k++) begin
      chk(P.wq[k], {ecol(10'h006, k, 10'h003, 1'b0), 8'(k),
          64'h100 + 64'(k)}, "write");
    end
    load_mode(3'h2, 1'b0, 3'h2, 1'b1);
    wr(10'h006);
    chk(64'(P.wq.size()), 64'h1, "single write");
    chk(P.wq[0], {10'h006, 8'h0, 64'h100}, "single data");
    load_mode(3'h3, 1'b0, 3'h2, 1'b0);
    stall <= 1'b1;
    wr(10'h000);
    chk(write_dropped, 1'b1, "dropped");
    chk(wr_valid, 1'b1, "held");
    chk({wr_bank, wr_row}, {2'h2, ROW}, "write row");
    stall <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(64'(P.wq.size()), 64'h2, "buffer");
    chk(P.wq[1][81:72], 10'h001, "buffer order");
    $display("test writes done");
    cmd(REF, 2'h0, 13'h0, 1'b1);
    chk(refresh_pulse, 1'b1, "refresh");
    r0 = refresh_row;
    @(posedge core_clk);
    #1;
    chk(refresh_pulse, 1'b0, "refresh pulse");
    cmd(REF, 2'h3, 13'h1FFF, 1'b1);
    chk(refresh_row !== r0, 1'b1, "refresh row");
    cmd(REF, 2'h0, 13'h0, 1'b0);
    chk(self_refresh, 1'b1, "self entry");
    cmd(ACT, 2'h1, 13'h0, 1'b0);
    cmd(NOP, 2'h0, 13'h0, 1'b1);
    @(posedge core_clk);
    #1;
    chk(self_refresh, 1'b0, "self exit");
    chk(bank_open, 4'h4, "ignored");
    cmd(ACT, 2'h0, 13'h0011, 1'b1);
    cmd(ACT, 2'h3, 13'h0022, 1'b1);
    chk(bank_open, 4'hD, "activate");
    cmd(4'hB, 2'h1, 13'h0, 1'b1);
    chk(bank_open, 4'hD, "inhibit");
    cmd(PRE, 2'h0, 13'h0, 1'b1);
    chk(bank_open, 4'hC, "close one");
    cmd(PRE, 2'h1, 13'h0400, 1'b1);
    chk(bank_open, 4'h0, "close all");
    $display("test commands done");
    test_done();
  end
endmodule
